// ==== core/mbsfh_consts.svh ====
// Constants of the server frame handler: frame layout, codes, sizes.
// Assumes inclusion by bare name from the handler's core.
`ifndef MBSFH_CONSTS_SVH
`define MBSFH_CONSTS_SVH
`define MBSFH_HDR_LEN 16'h0007
`define MBSFH_LEN_BASE 16'h0006
`define MBSFH_POS_FC 7
`define MBSFH_POS_START 8
`define MBSFH_POS_CNT 10
`define MBSFH_POS_WDATA 13
`define MBSFH_FC_RELAY_RD 8'h01
`define MBSFH_FC_INPUT_RD 8'h02
`define MBSFH_FC_HOLD_RD 8'h03
`define MBSFH_FC_RELAY_FORCE 8'h05
`define MBSFH_FC_MULTI_WR 8'h10
`define MBSFH_FC_EXC_FLAG 8'h80
`define MBSFH_EXC_BAD_FC 8'h01
`define MBSFH_PROTO_ID 16'h0000
`define MBSFH_FORCE_ON 16'hff00
`define MBSFH_FORCE_OFF 16'h0000
`define MBSFH_RELAYS 8
`define MBSFH_INPUTS 38
`define MBSFH_BUF_DEPTH 260
`define MBSFH_ECHO_LEN 16'h0006
`define MBSFH_RD_LEN_BASE 16'h0003
`endif

// ==== core/mbsfh_pkg.sv ====
// Types shared by the server frame handler.
// Needs nothing from mbsfh_consts.svh; holds the state encoding only.
package mbsfh_pkg;
   typedef enum logic [2:0] {
      ST_RECV = 3'b000,
      ST_EXEC = 3'b001,
      ST_WRITE = 3'b010,
      ST_LOAD = 3'b011,
      ST_SEND = 3'b100
   } mbsfh_state_t;
endpackage

// ==== core/mbsfh_core.sv ====
// Modbus-TCP server frame handler: takes request bytes, acts, sends the response bytes.
// Assumes a byte stream from the TCP layer on core_clk and a holding register store
// whose read data follows regRdAddr in the same cycle.
`include "mbsfh_consts.svh"
module mbsfh_core #(
   parameter int DEPTH = `MBSFH_BUF_DEPTH,
   parameter int INPUTS = `MBSFH_INPUTS
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   output logic rxReady,
   output logic txValid,
   output logic [7:0] txData,
   output logic txLast,
   input wire logic txReady,
   input wire logic [INPUTS-1:0] discreteInputLine,
   output logic [`MBSFH_RELAYS-1:0] relayOut,
   output logic [15:0] regRdAddr,
   input wire logic [15:0] regRdData,
   output logic regWrEn,
   output logic [15:0] regWrAddr,
   output logic [15:0] regWrData
);
   mbsfh_pkg::mbsfh_state_t state_q;
   logic [7:0] frameBuf [DEPTH];
   logic [15:0] rxCnt_q;
   logic [15:0] txIdx_q;
   logic [15:0] wrIdx_q;
   logic [7:0] txData_q;
   logic [`MBSFH_RELAYS-1:0] relay_q;
   logic [INPUTS-1:0] inMeta_q;
   logic [INPUTS-1:0] inSync_q;
   logic regWrEn_q;
   logic [15:0] regWrAddr_q;
   logic [15:0] regWrData_q;

   // Request fields, high byte first
   wire [15:0] protoId = {frameBuf[2], frameBuf[3]};
   wire [15:0] reqLen = {frameBuf[4], frameBuf[5]};
   wire [7:0] funcCode = frameBuf[`MBSFH_POS_FC];
   wire [15:0] startAddr = {frameBuf[`MBSFH_POS_START], frameBuf[`MBSFH_POS_START+1]};
   wire [15:0] itemCnt = {frameBuf[`MBSFH_POS_CNT], frameBuf[`MBSFH_POS_CNT+1]};
   wire [15:0] forceVal = itemCnt;

   wire isRelayRd = funcCode == `MBSFH_FC_RELAY_RD;
   wire isInputRd = funcCode == `MBSFH_FC_INPUT_RD;
   wire isHoldRd = funcCode == `MBSFH_FC_HOLD_RD;
   wire isForce = funcCode == `MBSFH_FC_RELAY_FORCE;
   wire isMultiWr = funcCode == `MBSFH_FC_MULTI_WR;
   wire isStatus = isRelayRd | isInputRd;
   wire isEcho = isForce | isMultiWr;
   wire isKnown = isStatus | isHoldRd | isEcho;

   // Receive side
   wire rxTake = rxValid & rxReady;
   wire [15:0] frameTotal = 16'(`MBSFH_LEN_BASE + reqLen);
   wire rxDone = rxTake && (rxCnt_q >= `MBSFH_HDR_LEN) && (16'(rxCnt_q + 16'h0001) >= frameTotal);

   // Response sizing
   wire [16:0] statBytes17 = (17'(itemCnt) + 17'h00007) >> 3;
   wire [7:0] statBytes = statBytes17[7:0];
   wire [7:0] holdBytes = 8'({itemCnt, 1'b0});
   wire [7:0] dataBytes = isStatus ? statBytes : holdBytes;
   wire [15:0] respLen = isEcho ? `MBSFH_ECHO_LEN :
      isKnown ? 16'(`MBSFH_RD_LEN_BASE + 16'(dataBytes)) : `MBSFH_RD_LEN_BASE;
   wire [15:0] respTotal = 16'(`MBSFH_LEN_BASE + respLen);
   wire [15:0] rdWord = 16'(txIdx_q - 16'h0009) >> 1;
   wire [15:0] statIdx = 16'(txIdx_q - 16'h0009);

   // Packed status byte k, first requested item in bit 0, zero past the count
   function automatic logic [7:0] statusByte(input logic [15:0] k);
      logic [7:0] b;
      logic [16:0] pos;
      logic [16:0] item;
      b = 8'h00;
      for (int j = 0; j < 8; j++) begin
         pos = 17'({k, 3'b000}) + 17'(j);
         item = 17'(startAddr) + pos;
         if (pos < 17'(itemCnt)) begin
            if (isRelayRd && item < 17'(`MBSFH_RELAYS)) begin
               b[j] = relay_q[item[2:0]];
            end else if (isInputRd && item < 17'(INPUTS)) begin
               b[j] = inSync_q[item[$clog2(INPUTS)-1:0]];
            end
         end
      end
      return b;
   endfunction

   // Response byte at position idx
   function automatic logic [7:0] respByte(input logic [15:0] idx);
      logic [7:0] b;
      b = 8'h00;
      if (idx < 16'h0004 || idx == 16'h0006) begin
         b = frameBuf[idx[2:0]];
      end else if (idx == 16'h0004) begin
         b = respLen[15:8];
      end else if (idx == 16'h0005) begin
         b = respLen[7:0];
      end else if (idx == 16'h0007) begin
         b = isKnown ? funcCode : (funcCode | `MBSFH_FC_EXC_FLAG);
      end else if (isEcho) begin
         b = frameBuf[idx[3:0]];
      end else if (idx == 16'h0008) begin
         b = isKnown ? dataBytes : `MBSFH_EXC_BAD_FC;
      end else if (isStatus) begin
         b = statusByte(statIdx);
      end else begin
         b = statIdx[0] ? regRdData[7:0] : regRdData[15:8];
      end
      return b;
   endfunction

   // A process, not a net assignment, so store read data and relay state retrigger it
   logic [7:0] nextByte;
   always_comb nextByte = respByte(txIdx_q);
   wire txTake = txValid & txReady;
   wire lastByte = 16'(txIdx_q + 16'h0001) >= respTotal;
   wire [15:0] wrPos = 16'(`MBSFH_POS_WDATA + 16'({wrIdx_q[14:0], 1'b0}));
   wire [15:0] wrPosNext = 16'(wrPos + 16'h0001);
   wire wrFits = 32'(wrPos) + 32'd1 < 32'(DEPTH);
   wire wrLast = 16'(wrIdx_q + 16'h0001) >= itemCnt || !wrFits;

   assign rxReady = state_q == mbsfh_pkg::ST_RECV;
   assign txValid = state_q == mbsfh_pkg::ST_SEND;
   assign txData = txData_q;
   assign txLast = txValid & lastByte;
   assign relayOut = relay_q;
   assign regRdAddr = 16'(startAddr + rdWord);
   assign regWrEn = regWrEn_q;
   assign regWrAddr = regWrAddr_q;
   assign regWrData = regWrData_q;

   // Discrete inputs come from pins
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         inMeta_q <= '0;
         inSync_q <= '0;
      end else if (ce) begin
         inMeta_q <= discreteInputLine;
         inSync_q <= inMeta_q;
      end
   end

   // Frame store
   always_ff @(posedge core_clk) begin
      if (ce && rxTake && 32'(rxCnt_q) < 32'(DEPTH)) begin
         frameBuf[rxCnt_q[$clog2(DEPTH)-1:0]] <= rxData;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= mbsfh_pkg::ST_RECV;
         rxCnt_q <= 16'h0000;
         txIdx_q <= 16'h0000;
         wrIdx_q <= 16'h0000;
         txData_q <= 8'h00;
         relay_q <= '0;
         regWrEn_q <= 1'b0;
         regWrAddr_q <= 16'h0000;
         regWrData_q <= 16'h0000;
      end else if (ce) begin
         regWrEn_q <= 1'b0;
         unique case (state_q)
            mbsfh_pkg::ST_RECV: begin
               if (rxDone) begin
                  rxCnt_q <= 16'h0000;
                  state_q <= mbsfh_pkg::ST_EXEC;
               end else if (rxTake) begin
                  rxCnt_q <= 16'(rxCnt_q + 16'h0001);
               end
            end
            mbsfh_pkg::ST_EXEC: begin
               txIdx_q <= 16'h0000;
               wrIdx_q <= 16'h0000;
               if (protoId != `MBSFH_PROTO_ID) begin
                  state_q <= mbsfh_pkg::ST_RECV;
               end else if (isMultiWr && itemCnt != 16'h0000) begin
                  state_q <= mbsfh_pkg::ST_WRITE;
               end else begin
                  state_q <= mbsfh_pkg::ST_LOAD;
               end
               if (isForce && protoId == `MBSFH_PROTO_ID && startAddr < 16'(`MBSFH_RELAYS)) begin
                  if (forceVal == `MBSFH_FORCE_ON) begin
                     relay_q[startAddr[2:0]] <= 1'b1;
                  end else if (forceVal == `MBSFH_FORCE_OFF) begin
                     relay_q[startAddr[2:0]] <= 1'b0;
                  end
               end
            end
            mbsfh_pkg::ST_WRITE: begin
               regWrEn_q <= wrFits;
               regWrAddr_q <= 16'(startAddr + wrIdx_q);
               regWrData_q <= {frameBuf[wrPos[$clog2(DEPTH)-1:0]], frameBuf[wrPosNext[$clog2(DEPTH)-1:0]]};
               wrIdx_q <= 16'(wrIdx_q + 16'h0001);
               if (wrLast) begin
                  state_q <= mbsfh_pkg::ST_LOAD;
               end
            end
            mbsfh_pkg::ST_LOAD: begin
               txData_q <= nextByte;
               state_q <= mbsfh_pkg::ST_SEND;
            end
            mbsfh_pkg::ST_SEND: begin
               if (txTake) begin
                  txIdx_q <= 16'(txIdx_q + 16'h0001);
                  state_q <= lastByte ? mbsfh_pkg::ST_RECV : mbsfh_pkg::ST_LOAD;
               end
            end
            default: state_q <= mbsfh_pkg::ST_RECV;
         endcase
      end
   end

   chk_rx_closed: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_q != mbsfh_pkg::ST_RECV) |-> !rxReady && !(rxTake && txValid))
      else $error("request byte taken while answering");
   chk_tid_copy: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && txIdx_q == 16'h0000 |-> txData == frameBuf[0])
      else $error("transaction id not echoed");
   chk_proto_drop: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && state_q == mbsfh_pkg::ST_EXEC && protoId != 16'h0000 |=> state_q == mbsfh_pkg::ST_RECV)
      else $error("foreign protocol frame answered");
   chk_len_low: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && txIdx_q == 16'h0005 |-> txData == respLen[7:0])
      else $error("length low byte wrong");
   chk_unit_copy: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && txIdx_q == 16'h0006 |-> txData == frameBuf[6])
      else $error("unit id not echoed");
   chk_relay_on: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && state_q == mbsfh_pkg::ST_EXEC && protoId == 16'h0000 && isForce && forceVal == 16'hff00
      && startAddr < 16'h0008 |=> relay_q[$past(startAddr[2:0])])
      else $error("relay not forced on");
   chk_relay_keep: assert property (@(posedge core_clk) disable iff (!rstn)
      state_q == mbsfh_pkg::ST_EXEC && isForce && forceVal != 16'hff00 && forceVal != 16'h0000
      |=> $stable(relay_q))
      else $error("invalid force value changed relays");
   chk_write_strobe: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && state_q == mbsfh_pkg::ST_WRITE && wrFits |=> regWrEn && regWrAddr == $past(16'(startAddr + wrIdx_q)))
      else $error("register write missing");
   chk_one_reply: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && txTake && lastByte |=> state_q == mbsfh_pkg::ST_RECV && !txValid)
      else $error("response did not end after last byte");

   // Receive closes once a frame is complete
   chk_rx_stop: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && state_q == mbsfh_pkg::ST_RECV && rxDone |=> !rxReady)
      else $error("receive stayed open after frame end");
   chk_idle_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
      state_q == mbsfh_pkg::ST_RECV |-> !txValid && !txLast)
      else $error("response byte offered while receiving");
   // Response header and body checks, then the relay force-off check
   chk_proto_copy: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && txIdx_q == 16'h0002 |-> txData == frameBuf[2])
      else $error("protocol id not echoed");
   chk_len_high: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && txIdx_q == 16'h0004 |-> txData == respLen[15:8])
      else $error("length high byte wrong");
   chk_fc_echo: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && txIdx_q == 16'h0007 && isKnown |-> txData == funcCode)
      else $error("function code not echoed");
   chk_exc_code: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && txIdx_q == 16'h0007 && !isKnown |-> txData == (funcCode | 8'h80))
      else $error("unknown code not flagged");
   chk_echo_body: assert property (@(posedge core_clk) disable iff (!rstn)
      txValid && isEcho && txIdx_q >= 16'h0007 && txIdx_q < 16'h000c |-> txData == frameBuf[txIdx_q[3:0]])
      else $error("echoed body differs from request");
   chk_relay_off: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && state_q == mbsfh_pkg::ST_EXEC && protoId == 16'h0000 && isForce && forceVal == 16'h0000
      && startAddr < 16'h0008 |=> !relay_q[$past(startAddr[2:0])])
      else $error("relay not forced off");
endmodule

// ==== dv/mbsfh_regstore.sv ====
// Holding register store on the far side of the frame handler.
// Assumes the handler reads combinationally and writes on single-cycle strobes.
module mbsfh_regstore (
   input wire logic core_clk,
   input wire logic [15:0] regRdAddr,
   output logic [15:0] regRdData,
   input wire logic regWrEn,
   input wire logic [15:0] regWrAddr,
   input wire logic [15:0] regWrData,
   output int nWrites
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [256];
   initial begin
      nWrites = 0;
      foreach (mem[i]) mem[i] = 16'h0000;
   end
   assign regRdData = mem[regRdAddr[7:0]];
   always @(posedge core_clk) begin
      if (regWrEn === 1'b1) begin
         mem[regWrAddr[7:0]] <= regWrData;
         nWrites <= nWrites + 1;
      end
   end
endmodule

// ==== dv/mbsfh_core_tb.sv ====
// Self-checking bench for the server frame handler.
// Assumes the response sink is always ready and the register store answers at once.
module mbsfh_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [7:0] mbsfh_bytes_t[$];
   logic core_clk, rstn, rxValid, rxReady, txValid, txLast, regWrEn;
   logic [7:0] rxData, txData, relayOut;
   logic [37:0] inLines;
   logic [15:0] regRdAddr, regRdData, regWrAddr, regWrData, tid, protoTx;
   int nMismatch, checks, nWrites;
   mbsfh_bytes_t rsp;
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   mbsfh_core dut (.core_clk(core_clk), .rstn(rstn), .ce(1'b1), .rxValid(rxValid), .rxData(rxData),
      .rxReady(rxReady), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(1'b1),
      .discreteInputLine(inLines), .relayOut(relayOut), .regRdAddr(regRdAddr), .regRdData(regRdData),
      .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData));
   mbsfh_regstore store (.core_clk(core_clk), .regRdAddr(regRdAddr), .regRdData(regRdData),
      .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData), .nWrites(nWrites));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic timeout(input string msg);
      nMismatch++;
      $display("CHECK FAILED at %0t: %s timed out", $time, msg);
      report_and_stop();
   endtask
   function automatic mbsfh_bytes_t frame(input logic [7:0] fc, input mbsfh_bytes_t d);
      logic [15:0] len;
      mbsfh_bytes_t q;
      len = 16'(d.size() + 2);
      q = {tid[15:8], tid[7:0], protoTx[15:8], protoTx[7:0], len[15:8], len[7:0], 8'h11, fc};
      return {q, d};
   endfunction
   // Sends one request and collects the whole response
   task automatic xact(input logic [7:0] fc, input mbsfh_bytes_t d);
      mbsfh_bytes_t q;
      int n;
      logic done;
      tid = tid + 16'h0101;
      q = frame(fc, d);
      foreach (q[i]) begin
         @(negedge core_clk);
         rxValid = 1'b1;
         rxData = q[i];
         n = 0;
         while (rxReady !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
         end
         if (n >= 100) timeout("request");
         @(posedge core_clk);
      end
      @(negedge core_clk);
      rxValid = 1'b0;
      rsp.delete();
      done = 1'b0;
      for (n = 0; n < 400 && !done; n++) begin
         @(negedge core_clk);
         if (txValid === 1'b1) begin
            rsp.push_back(txData);
            done = (txLast === 1'b1);
         end
      end
      if (!done && protoTx == 16'h0000) timeout("response");
   endtask
   task automatic expect_rsp(input logic [7:0] fc, input mbsfh_bytes_t e);
      mbsfh_bytes_t q;
      q = frame(fc, e);
      chk8(8'(rsp.size()), 8'(q.size()), "response length");
      foreach (q[i]) chk8((i < rsp.size()) ? rsp[i] : 8'hxx, q[i], "response byte");
   endtask
   task automatic test_force;
      xact(8'h05, '{8'h00, 8'h03, 8'hff, 8'h00});
      expect_rsp(8'h05, '{8'h00, 8'h03, 8'hff, 8'h00});
      chk8(relayOut, 8'h08, "relay on");
      xact(8'h05, '{8'h00, 8'h03, 8'h12, 8'h34});
      expect_rsp(8'h05, '{8'h00, 8'h03, 8'h12, 8'h34});
      chk8(relayOut, 8'h08, "relay kept");
      $display("test force done");
   endtask
   task automatic test_proto;
      protoTx = 16'h0001;
      xact(8'h05, '{8'h00, 8'h01, 8'hff, 8'h00});
      protoTx = 16'h0000;
      chk8(8'(rsp.size()), 8'h00, "foreign frame answered");
      chk8(relayOut, 8'h08, "foreign force applied");
      $display("test protocol done");
   endtask
   task automatic test_status;
      xact(8'h01, '{8'h00, 8'h02, 8'h00, 8'h03});
      expect_rsp(8'h01, '{8'h01, 8'h02});
      xact(8'h02, '{8'h00, 8'h04, 8'h00, 8'h0c});
      expect_rsp(8'h02, '{8'h02, 8'h0a, 8'h0f});
      xact(8'h02, '{8'h00, 8'h24, 8'h00, 8'h04});
      expect_rsp(8'h02, '{8'h01, 8'h02});
      $display("test status done");
   endtask
   task automatic test_regs;
      xact(8'h10, '{8'h10, 8'h08, 8'h00, 8'h02, 8'h04, 8'h01, 8'hf4, 8'h00, 8'h05});
      expect_rsp(8'h10, '{8'h10, 8'h08, 8'h00, 8'h02});
      chk8(8'(nWrites), 8'h02, "write count");
      xact(8'h03, '{8'h10, 8'h08, 8'h00, 8'h02});
      expect_rsp(8'h03, '{8'h04, 8'h01, 8'hf4, 8'h00, 8'h05});
      xact(8'h2b, '{8'h00, 8'h00});
      expect_rsp(8'hab, '{8'h01});
      $display("test registers done");
   endtask
   initial begin
      rstn = 1'b0;
      rxValid = 1'b0;
      rxData = 8'h00;
      inLines = 38'h20_0000_f0a5;
      tid = 16'h0000;
      protoTx = 16'h0000;
      nMismatch = 0;
      checks = 0;
      repeat (20) @(negedge core_clk);
      rstn = 1'b1;
      test_force();
      test_proto();
      test_status();
      test_regs();
      report_and_stop();
   end
endmodule
